// file: hdl/rfc_pkg.sv
package rfc_pkg;
  // register offsets on the configuration port
  localparam logic [5:0] ADDR_RX_FRONT_END_CONFIG = 6'h21;
  localparam logic [5:0] ADDR_TX_FRONT_END_CONFIG = 6'h22;
  localparam logic [5:0] ADDR_SYNTH_CAL_CHARGE_PUMP = 6'h23;
  localparam logic [5:0] ADDR_SYNTH_CAL_VCO_CURRENT = 6'h24;
  // writable bit masks, other bits read zero
  localparam logic [7:0] MASK_RX_FRONT_END = 8'hFF;
  localparam logic [7:0] MASK_TX_FRONT_END = 8'h37;
  localparam logic [7:0] MASK_CHARGE_PUMP = 8'hFF;
  localparam logic [7:0] MASK_VCO_CURRENT = 8'h3F;
  // reset values
  localparam logic [7:0] RST_RX_FRONT_END = 8'h56;
  localparam logic [7:0] RST_TX_FRONT_END = 8'h10;
  localparam logic [7:0] RST_CHARGE_PUMP = 8'hA9;
  localparam logic [7:0] RST_VCO_CURRENT = 8'h0A;
  // field positions
  localparam int POWER_INDEX_LSB = 0;
  localparam int POWER_INDEX_W = 3;
  localparam int TX_LO_BUF_LSB = 4;
  localparam int CAL_CONFIG_LSB = 6;
  localparam int CP_CAL_EN_LSB = 4;
  localparam int CP_RESULT_LSB = 0;
  localparam int VCO_HIGH_BIT = 5;
  localparam int VCO_CURRENT_LSB = 0;
  localparam int TABLE_DEPTH = 8;
  // cycles each ramp step holds its table entry
  localparam logic [3:0] RAMP_STEP_CYCLES = 4'h4;
  // zero symbol run after which entry zero must stand, worst case start
  localparam logic [6:0] KEY_SETTLE_CYCLES = 7'h60;
  typedef enum logic [1:0] {
    RFC_IDLE, RFC_RAMP_UP, RFC_ON, RFC_RAMP_DOWN
  } rfc_ramp_e;
endpackage

// file: hdl/rfc_power_ramp.sv
`timescale 1ns/1ps
`default_nettype none
// power table index sequencer for ramps and keying
module rfc_power_ramp (
  input wire logic clock, // system clock
  input wire logic reset_n, // async reset, low
  input wire logic [2:0] power_index, // top table entry
  input wire logic tx_active, // burst in progress
  input wire logic ook_mode, // on/off or amplitude keying
  input wire logic tx_symbol, // current symbol
  output logic [2:0] table_sel_q // selected table entry
);
  rfc_pkg::rfc_ramp_e state_q;
  logic [3:0] step_q;
  logic step_done;
  logic [2:0] key_target;

  assign step_done = (step_q == rfc_pkg::RAMP_STEP_CYCLES - 4'h1);
  // in on/off keying a zero symbol uses entry zero, otherwise the index is used
  assign key_target = (ook_mode && !tx_symbol) ? 3'h0 : power_index;

  // step timer
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      step_q <= 4'h0;
    end else if (state_q == rfc_pkg::RFC_IDLE || step_done) begin
      step_q <= 4'h0;
    end else begin
      step_q <= step_q + 4'h1;
    end
  end

  // ramp state and table entry walk from zero to the index
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= rfc_pkg::RFC_IDLE;
      table_sel_q <= 3'h0;
    end else begin
      case (state_q)
        rfc_pkg::RFC_IDLE: begin
          table_sel_q <= 3'h0;
          if (tx_active) begin
            state_q <= rfc_pkg::RFC_RAMP_UP;
          end
        end
        rfc_pkg::RFC_RAMP_UP: begin
          if (!tx_active) begin
            state_q <= rfc_pkg::RFC_RAMP_DOWN;
          end else if (table_sel_q >= power_index) begin
            table_sel_q <= power_index;
            state_q <= rfc_pkg::RFC_ON;
          end else if (step_done) begin
            table_sel_q <= table_sel_q + 3'h1;
          end
        end
        rfc_pkg::RFC_ON: begin
          if (!tx_active) begin
            state_q <= rfc_pkg::RFC_RAMP_DOWN;
          end else if (step_done && table_sel_q < key_target) begin
            table_sel_q <= table_sel_q + 3'h1;
          end else if (step_done && table_sel_q > key_target) begin
            table_sel_q <= table_sel_q - 3'h1;
          end
        end
        rfc_pkg::RFC_RAMP_DOWN: begin
          if (table_sel_q == 3'h0) begin
            state_q <= rfc_pkg::RFC_IDLE;
          end else if (step_done) begin
            table_sel_q <= table_sel_q - 3'h1;
          end
        end
        default: begin
          state_q <= rfc_pkg::RFC_IDLE;
        end
      endcase
    end
  end

  // entry stays at or below an unchanged index while keying
  a_sel_bounded: assert property (@(posedge clock) disable iff (!reset_n)
    (state_q == rfc_pkg::RFC_ON && $stable(power_index)) |=>
      table_sel_q <= power_index)
    else $error("table entry above power index");
  // ramp down ends at entry zero within the bound
  a_down_reaches_zero: assert property (@(posedge clock) disable iff (!reset_n)
    $fell(tx_active) |-> ##[1:40] table_sel_q == 3'h0)
    else $error("ramp down did not reach entry zero");
endmodule
`default_nettype wire

// file: hdl/rfc_cal_regs.sv
`timescale 1ns/1ps
`default_nettype none
module rfc_cal_regs (
  input wire logic clock, // 40 MHz system clock
  input wire logic reset_n, // async reset, low
  input wire logic cfg_wr_en, // config port write strobe
  input wire logic [5:0] cfg_addr, // config port register address
  input wire logic [7:0] cfg_wdata, // config port write data
  output logic [7:0] cfg_rdata_q, // config port read data
  input wire logic cal_done, // calibration finished pulse
  input wire logic [3:0] cal_cp_result, // charge pump cal result
  input wire logic [4:0] cal_vco_result, // vco current cal result
  input wire logic tx_active, // transmit burst in progress
  input wire logic ook_mode, // on/off or amplitude keying
  input wire logic tx_symbol, // current transmitted symbol
  output logic [2:0] amp_setting_table_sel, // selected table entry
  output logic [1:0] tx_lo_buffer_current, // lo buffer drive
  output logic [1:0] cal_config, // calibration configuration
  output logic charge_pump_cal_enable, // run charge pump cal stage
  output logic [3:0] charge_pump_current, // charge pump current code
  output logic vco_high_core_select, // high vco core when set
  output logic [4:0] vco_current, // vco current code
  output logic [7:0] rx_front_end_bits // receive front end field
);
  logic [7:0] rx_front_end_config_q;
  logic [7:0] tx_front_end_config_q;
  logic [7:0] synth_cal_charge_pump_q;
  logic [7:0] synth_cal_vco_current_q;
  logic [7:0] rdata_d;
  logic [2:0] power_table_index;
  logic [6:0] key_zero_run_q;

  // receive front end register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_front_end_config_q <= rfc_pkg::RST_RX_FRONT_END;
    end else if (cfg_wr_en &&
                 cfg_addr == rfc_pkg::ADDR_RX_FRONT_END_CONFIG) begin
      rx_front_end_config_q <= cfg_wdata & rfc_pkg::MASK_RX_FRONT_END;
    end
  end

  // transmit front end register, reserved bits held at zero
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_front_end_config_q <= rfc_pkg::RST_TX_FRONT_END;
    end else if (cfg_wr_en &&
                 cfg_addr == rfc_pkg::ADDR_TX_FRONT_END_CONFIG) begin
      tx_front_end_config_q <= cfg_wdata & rfc_pkg::MASK_TX_FRONT_END;
    end
  end

  // charge pump register: host write overrides, cal result loads when charge_pump_cal_enable is set
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      synth_cal_charge_pump_q <= rfc_pkg::RST_CHARGE_PUMP;
    end else if (cfg_wr_en &&
                 cfg_addr == rfc_pkg::ADDR_SYNTH_CAL_CHARGE_PUMP) begin
      synth_cal_charge_pump_q <= cfg_wdata;
    end else if (cal_done && charge_pump_cal_enable) begin
      synth_cal_charge_pump_q[rfc_pkg::CP_RESULT_LSB +: 4] <=
        cal_cp_result;
    end
  end

  // vco register: host write is an override of the cal result
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      synth_cal_vco_current_q <= rfc_pkg::RST_VCO_CURRENT;
    end else if (cfg_wr_en &&
                 cfg_addr == rfc_pkg::ADDR_SYNTH_CAL_VCO_CURRENT) begin
      synth_cal_vco_current_q <=
        cfg_wdata & rfc_pkg::MASK_VCO_CURRENT;
    end else if (cal_done) begin
      synth_cal_vco_current_q[rfc_pkg::VCO_CURRENT_LSB +: 5] <=
        cal_vco_result;
    end
  end

  // read data mux, unmapped addresses read zero
  always_comb begin
    rdata_d = 8'h00;
    case (cfg_addr)
      rfc_pkg::ADDR_RX_FRONT_END_CONFIG: rdata_d = rx_front_end_config_q;
      rfc_pkg::ADDR_TX_FRONT_END_CONFIG: rdata_d = tx_front_end_config_q;
      rfc_pkg::ADDR_SYNTH_CAL_CHARGE_PUMP: rdata_d = synth_cal_charge_pump_q;
      rfc_pkg::ADDR_SYNTH_CAL_VCO_CURRENT: rdata_d = synth_cal_vco_current_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // registered read data
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cfg_rdata_q <= 8'h00;
    end else begin
      cfg_rdata_q <= rdata_d;
    end
  end

  // field outputs
  assign power_table_index =
    tx_front_end_config_q[rfc_pkg::POWER_INDEX_LSB +: 3];
  assign tx_lo_buffer_current =
    tx_front_end_config_q[rfc_pkg::TX_LO_BUF_LSB +: 2];
  assign cal_config = synth_cal_charge_pump_q[rfc_pkg::CAL_CONFIG_LSB +: 2];
  assign charge_pump_cal_enable =
    |synth_cal_charge_pump_q[rfc_pkg::CP_CAL_EN_LSB +: 2];
  assign charge_pump_current =
    synth_cal_charge_pump_q[rfc_pkg::CP_RESULT_LSB +: 4];
  assign vco_high_core_select =
    synth_cal_vco_current_q[rfc_pkg::VCO_HIGH_BIT];
  assign vco_current = synth_cal_vco_current_q[rfc_pkg::VCO_CURRENT_LSB +: 5];
  assign rx_front_end_bits = rx_front_end_config_q;

  // table entry sequencer
  rfc_power_ramp u_ramp (
    .clock(clock),
    .reset_n(reset_n),
    .power_index(power_table_index),
    .tx_active(tx_active),
    .ook_mode(ook_mode),
    .tx_symbol(tx_symbol),
    .table_sel_q(amp_setting_table_sel)
  );

  // run length of zero symbols while keying, saturates
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      key_zero_run_q <= 7'h00;
    end else if (!(tx_active && ook_mode && !tx_symbol)) begin
      key_zero_run_q <= 7'h00;
    end else if (key_zero_run_q != 7'h7F) begin
      key_zero_run_q <= key_zero_run_q + 7'h01;
    end
  end

  // host writes seen on the configuration port
  sequence s_wr_rx;
    cfg_wr_en && cfg_addr == rfc_pkg::ADDR_RX_FRONT_END_CONFIG;
  endsequence
  sequence s_wr_tx;
    cfg_wr_en && cfg_addr == rfc_pkg::ADDR_TX_FRONT_END_CONFIG;
  endsequence
  sequence s_wr_cp;
    cfg_wr_en && cfg_addr == rfc_pkg::ADDR_SYNTH_CAL_CHARGE_PUMP;
  endsequence
  sequence s_wr_vco;
    cfg_wr_en && cfg_addr == rfc_pkg::ADDR_SYNTH_CAL_VCO_CURRENT;
  endsequence

  // reserved bits of the transmit register never read one
  a_tx_reserved_zero: assert property (@(posedge clock) disable iff (!reset_n)
    (tx_front_end_config_q & ~rfc_pkg::MASK_TX_FRONT_END) == 8'h00)
    else $error("reserved tx bits set");
  // a written vco value appears on the outputs next cycle
  a_vco_override: assert property (@(posedge clock) disable iff (!reset_n)
    (cfg_wr_en && cfg_addr == rfc_pkg::ADDR_SYNTH_CAL_VCO_CURRENT) |=>
      vco_current == $past(cfg_wdata[4:0]) &&
      vco_high_core_select == $past(cfg_wdata[5]))
    else $error("vco override not applied");
  // disabled charge pump cal keeps the stored code
  a_cp_cal_skip: assert property (@(posedge clock) disable iff (!reset_n)
    (cal_done && !charge_pump_cal_enable && !cfg_wr_en) |=>
      $stable(charge_pump_current))
    else $error("charge pump result changed while disabled");
  // calibration result stored when enabled
  a_cp_cal_load: assert property (@(posedge clock) disable iff (!reset_n)
    (cal_done && charge_pump_cal_enable && !cfg_wr_en) |=>
      charge_pump_current == $past(cal_cp_result))
    else $error("charge pump result not stored");
  // a long zero symbol run in keying settles on entry zero
  a_zero_symbol: assert property (@(posedge clock) disable iff (!reset_n)
    (key_zero_run_q >= rfc_pkg::KEY_SETTLE_CYCLES) |->
      amp_setting_table_sel == 3'h0)
    else $error("zero symbol not on entry zero");
  // lo buffer field follows the register
  a_lo_buffer: assert property (@(posedge clock) disable iff (!reset_n)
    (cfg_wr_en && cfg_addr == rfc_pkg::ADDR_TX_FRONT_END_CONFIG) |=>
      tx_lo_buffer_current == $past(cfg_wdata[5:4]))
    else $error("lo buffer current not updated");
  // power index field follows a transmit register write
  a_power_index: assert property (@(posedge clock) disable iff (!reset_n)
    s_wr_tx |=> power_table_index == $past(cfg_wdata[2:0]))
    else $error("power index not updated");
  // charge pump register takes the whole written byte
  a_cp_write: assert property (@(posedge clock) disable iff (!reset_n)
    s_wr_cp |=> synth_cal_charge_pump_q == $past(cfg_wdata))
    else $error("charge pump write not applied");
  // receive register takes the whole written byte
  a_rx_write: assert property (@(posedge clock) disable iff (!reset_n)
    s_wr_rx |=> rx_front_end_bits == $past(cfg_wdata))
    else $error("receive register write not applied");
  // vco current loads the cal result when the host is quiet
  a_vco_cal_load: assert property (@(posedge clock) disable iff (!reset_n)
    (cal_done && !cfg_wr_en) |=> vco_current == $past(cal_vco_result))
    else $error("vco cal result not stored");
  // reserved bits of the vco register never read one
  a_vco_rsvd_zero: assert property (@(posedge clock) disable iff (!reset_n)
    (synth_cal_vco_current_q & ~rfc_pkg::MASK_VCO_CURRENT) == 8'h00)
    else $error("reserved vco bits set");
  // unmapped addresses read zero one cycle later
  a_unmapped_zero: assert property (@(posedge clock) disable iff (!reset_n)
    (cfg_addr < rfc_pkg::ADDR_RX_FRONT_END_CONFIG ||
     cfg_addr > rfc_pkg::ADDR_SYNTH_CAL_VCO_CURRENT) |=>
      cfg_rdata_q == 8'h00)
    else $error("unmapped address read nonzero");
  // a vco register read shows its fields, reserved bits zero
  a_rdata_vco: assert property (@(posedge clock) disable iff (!reset_n)
    (cfg_addr == rfc_pkg::ADDR_SYNTH_CAL_VCO_CURRENT && !cfg_wr_en &&
     !cal_done) |=>
      cfg_rdata_q == {2'h0, vco_high_core_select, vco_current})
    else $error("vco register read mismatch");
endmodule
`default_nettype wire

// file: tb/rfc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host controller on the configuration port
module rfc_host_model (
  input wire logic clock, // system clock
  output logic cfg_wr_en, // write strobe
  output logic [5:0] cfg_addr, // register address
  output logic [7:0] cfg_wdata, // write data
  input wire logic [7:0] cfg_rdata_q // registered read data
);
  // idle port at time zero
  initial begin
    cfg_wr_en = 1'b0;
    cfg_addr = 6'h00;
    cfg_wdata = 8'h00;
  end
  // one byte write, strobe held across one edge
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    cfg_wr_en = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(posedge clock);
    #1;
    cfg_wr_en = 1'b0;
    cfg_wdata = ~d; // released data does not keep its value
  endtask
  // read: address taken at an edge, data valid after it
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clock);
    #1;
    cfg_addr = a;
    @(posedge clock);
    #1;
    d = cfg_rdata_q;
  endtask
endmodule
`default_nettype wire

// file: tb/rfc_cal_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module rfc_cal_regs_tb_top;
  logic clock, reset_n, cal_done, tx_active, ook_mode, tx_symbol;
  logic cfg_wr_en, charge_pump_cal_enable, vco_high_core_select;
  logic [5:0] cfg_addr;
  logic [7:0] cfg_wdata, cfg_rdata_q, rx_front_end_bits, rb, wv;
  logic [3:0] cal_cp_result, charge_pump_current;
  logic [4:0] cal_vco_result, vco_current;
  logic [2:0] amp_setting_table_sel, prev_sel;
  logic [1:0] tx_lo_buffer_current, cal_config;
  logic [7:0] mdl [0:3];
  logic [7:0] msk [0:3];
  logic [7:0] saved [0:3];
  int fails, n_compared, seed;

  rfc_cal_regs dut (.clock(clock), .reset_n(reset_n),
    .cfg_wr_en(cfg_wr_en), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rdata_q(cfg_rdata_q), .cal_done(cal_done),
    .cal_cp_result(cal_cp_result), .cal_vco_result(cal_vco_result),
    .tx_active(tx_active), .ook_mode(ook_mode), .tx_symbol(tx_symbol),
    .amp_setting_table_sel(amp_setting_table_sel),
    .tx_lo_buffer_current(tx_lo_buffer_current), .cal_config(cal_config),
    .charge_pump_cal_enable(charge_pump_cal_enable),
    .charge_pump_current(charge_pump_current),
    .vco_high_core_select(vco_high_core_select),
    .vco_current(vco_current), .rx_front_end_bits(rx_front_end_bits));
  rfc_host_model host (.clock(clock), .cfg_wr_en(cfg_wr_en),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q));

  // 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic check(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic test_done();
    if (fails == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // read back one register and all field outputs
  task automatic reg_chk(input int i);
    host.rd(6'(33 + i), rb);
    check("register", mdl[i], rb);
    check("lo_buffer", 8'(mdl[1][5:4]), 8'(tx_lo_buffer_current));
    check("cal_config", 8'(mdl[2][7:6]), 8'(cal_config));
    check("cp_enable", 8'(mdl[2][5:4] != 2'b00),
          8'(charge_pump_cal_enable));
    check("cp_current", 8'(mdl[2][3:0]), 8'(charge_pump_current));
    check("vco_high", 8'(mdl[3][5]), 8'(vco_high_core_select));
    check("vco_current", 8'(mdl[3][4:0]), 8'(vco_current));
    check("rx_bits", mdl[0], rx_front_end_bits);
  endtask
  task automatic wr_chk(input int i, input logic [7:0] d);
    host.wr(6'(33 + i), d);
    mdl[i] = d & msk[i];
    reg_chk(i);
  endtask
  // calibration finished pulse with random results
  task automatic cal_pulse();
    @(posedge clock);
    #1;
    cal_done = 1'b1;
    cal_cp_result = 4'($random(seed));
    cal_vco_result = 5'($random(seed));
    @(posedge clock);
    #1;
    cal_done = 1'b0;
    if (mdl[2][5:4] != 2'b00) mdl[2][3:0] = cal_cp_result;
    mdl[3][4:0] = cal_vco_result;
    reg_chk(2);
    reg_chk(3);
  endtask
  // transmit state, then settled table entry
  task automatic ramp(input logic act, input logic ook, input logic sym,
                      input logic [2:0] exp);
    @(posedge clock);
    #1;
    tx_active = act;
    ook_mode = ook;
    tx_symbol = sym;
    repeat (100) @(posedge clock);
    #1;
    check("table_sel", 8'(exp), 8'(amp_setting_table_sel));
  endtask
  // table entry moves one step at a time
  always @(negedge clock) begin
    if (reset_n === 1'b1 && (amp_setting_table_sel - prev_sel) > 3'd1 &&
        (prev_sel - amp_setting_table_sel) > 3'd1)
      check("ramp_step", 8'(prev_sel), 8'(amp_setting_table_sel));
    prev_sel <= amp_setting_table_sel;
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    test_done();
  end
  initial begin
    seed = 12;
    fails = 0;
    n_compared = 0;
    prev_sel = 3'h0;
    reset_n = 1'b0;
    cal_done = 1'b0;
    cal_cp_result = 4'h0;
    cal_vco_result = 5'h00;
    tx_active = 1'b0;
    ook_mode = 1'b0;
    tx_symbol = 1'b0;
    mdl = '{rfc_pkg::RST_RX_FRONT_END, rfc_pkg::RST_TX_FRONT_END,
            rfc_pkg::RST_CHARGE_PUMP, rfc_pkg::RST_VCO_CURRENT};
    msk = '{rfc_pkg::MASK_RX_FRONT_END, rfc_pkg::MASK_TX_FRONT_END,
            rfc_pkg::MASK_CHARGE_PUMP, rfc_pkg::MASK_VCO_CURRENT};
    repeat (20) @(posedge clock);
    #1;
    reset_n = 1'b1;
    // reset values and an unmapped address
    for (int i = 0; i < 4; i++) reg_chk(i);
    host.rd(6'h25, rb);
    check("unmapped", 8'h00, rb);
    // random writes over reserved bits
    repeat (6) begin
      for (int i = 0; i < 4; i++) wr_chk(i, 8'($random(seed)));
    end
    for (int v = 0; v < 4; v++) wr_chk(1, 8'(v << 4) | 8'hCF);
    wr_chk(3, 8'hE0);
    wr_chk(3, 8'h1F);
    // every charge pump enable code, zero skips its stage
    for (int e = 0; e < 4; e++) begin
      wr_chk(2, 8'h80 | 8'(e << 4) | 8'h03);
      cal_pulse();
    end
    // hop: save results, calibrate elsewhere, restore
    for (int i = 0; i < 4; i++) saved[i] = mdl[i];
    cal_pulse();
    for (int i = 2; i < 4; i++) wr_chk(i, saved[i]);
    // host write and cal result in one cycle: the write wins
    wv = 8'($random(seed));
    fork
      host.wr(6'h24, wv);
      begin
        @(posedge clock);
        #1;
        cal_done = 1'b1;
        @(posedge clock);
        #1;
        cal_done = 1'b0;
      end
    join
    if (mdl[2][5:4] != 2'b00) mdl[2][3:0] = cal_cp_result;
    mdl[3] = wv & msk[3];
    reg_chk(2);
    reg_chk(3);
    // ramp up, keying both symbols, ramp down
    for (int p = 7; p >= 0; p -= 3) begin
      wr_chk(1, 8'h10 | 8'(p));
      ramp(1'b1, 1'b0, 1'b0, 3'(p));
      ramp(1'b1, 1'b1, 1'b0, 3'h0);
      ramp(1'b1, 1'b1, 1'b1, 3'(p));
      ramp(1'b0, 1'b0, 1'b0, 3'h0);
    end
    test_done();
  end
endmodule
`default_nettype wire
